// ==== hdl/fnm_pkg.sv ====
/*
  Shared constants, state types and arithmetic helpers for the fractional-N
  reference path and its sigma-delta modulator.
  Assumes a single system clock domain; the reference pin is synchronised
  by the top module before any logic reads it.
*/
package fnm_pkg;

  // ----------------------------------------------------------------------
  // Configuration word layout
  // ----------------------------------------------------------------------
  localparam int REF_COUNT_LSB = 14;
  localparam int REF_COUNT_MSB = 23;
  localparam int REF_HALVER_POS = 24;

  // ----------------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------------
  localparam int REF_COUNT_W = 10;
  localparam int NUMERATOR_VALUE_W = 12;
  localparam int INT_W = 16;
  localparam int DIV_W = 17;
  localparam int LFSR_W = 21;
  localparam logic [9:0] REF_COUNT_RESET = 10'h000;
  localparam logic [11:0] ACC_RESET = 12'h000;
  localparam logic [11:0] DENOM_MIN = 12'h002;
  localparam logic [20:0] LFSR_SEED = 21'h000001;
  // Taps of x^21 + x^19 + 1, a maximal-length polynomial
  localparam int LFSR_TAP_A = 20;
  localparam int LFSR_TAP_B = 18;

  // ----------------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic ref_s1;
    logic ref_s2;
    logic ref_s3;
    logic [9:0] cnt;
    logic tgl;
    logic cmp_clk;
    logic cmp_tick;
  } fnm_ref_state_type;

  typedef struct packed {
    logic [11:0] acc1;
    logic [11:0] acc2;
    logic [11:0] acc3;
    logic c2_d;
    logic c3_d;
    logic c3_dd;
    logic [20:0] lfsr;
    logic [16:0] div;
  } fnm_sdm_state_type;

  localparam fnm_ref_state_type REF_STATE_RESET = '0;
  localparam fnm_sdm_state_type SDM_STATE_RESET = '{
    acc1: ACC_RESET, acc2: ACC_RESET, acc3: ACC_RESET, c2_d: 1'b0, c3_d: 1'b0,
    c3_dd: 1'b0, lfsr: LFSR_SEED, div: 17'h00000};

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // A count of zero would divide by 1024, so it behaves as one
  function automatic logic [9:0] fnm_eff_count(input logic [9:0] r);
    fnm_eff_count = (r == REF_COUNT_RESET) ? 10'h001 : r;
  endfunction

  // Denominators below the minimum are clamped to keep the modulo sane
  function automatic logic [11:0] fnm_eff_denom(input logic [11:0] m);
    fnm_eff_denom = (m < DENOM_MIN) ? DENOM_MIN : m;
  endfunction

  // Modulo add; returns {carry, sum}. Needs acc < m and inc <= m
  function automatic logic [12:0] fnm_mod_add(input logic [11:0] acc,
                                              input logic [12:0] inc,
                                              input logic [11:0] m);
    logic [12:0] s;
    logic [12:0] d;
    s = {1'b0, acc} + inc;
    d = s - {1'b0, m};
    if (s >= {1'b0, m}) begin
      fnm_mod_add = {1'b1, d[11:0]};
    end else begin
      fnm_mod_add = {1'b0, s[11:0]};
    end
  endfunction

endpackage

// ==== hdl/fnm_ref_path_mod.sv ====
/*
  Top of the fractional-N digital core: reference synchroniser, optional
  edge doubler, 10-bit reference counter, optional divide-by-two stage, and
  the sigma-delta modulator that sets the feedback divide value.
  Assumes REF_IN is asynchronous and slower than a quarter of CLK_SYS so
  that both edges are seen; configuration inputs are quasi-static and come
  from the same clock domain; LOAD is a one-cycle pulse.
*/
`timescale 1ns/100ps

// Operation
// [R1] Output = (int + num/den) times compare rate
// [R2] Compare rate = ref*(1+D)/(R*(1+T))
// [R3] Reference counter divides by 1 to 1023
// [R4] Doubler bit doubles reference before counter
// [R5] Configurer keeps compare rate at most 32 MHz
// [R6] Halver gives 50% duty compare clock
// [R7] Denominator is independent 12-bit field
// [R8] Third-order modulator, denominator 2 to 4095
// [R9] Configurer keeps denominator >= 50 with dither
// [R10] Modulator steps once per compare cycle
// [R11] Dither off: repeat length set by denominator
// [R12] Dither on: sequence repeat extended to 2^21
// [R13] Halver bit 24 inserts toggle flip-flop
// [R14] Reference count taken from bits 23:14
// [R15] Dither off: modulator seeded by phase word
// [R16] Configurer keeps numerator below denominator
module fnm_ref_path_mod
  import fnm_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Reference pin
  input wire logic REF_IN,
  // Reference path configuration
  input wire logic [31:0] REF_CONFIG_WORD,
  input wire logic DOUBLER_EN,
  // Fractional ratio configuration
  input wire logic [15:0] INT_VALUE,
  input wire logic [11:0] NUMERATOR_VALUE,
  input wire logic [11:0] DENOMINATOR_VALUE,
  input wire logic [11:0] PHASE_WORD,
  input wire logic DITHER_EN,
  input wire logic LOAD,
  // Phase detector side
  output logic COMPARE_CLK,
  output logic COMPARE_TICK,
  // Feedback counter side
  output logic [16:0] FB_DIVIDE
);

  fnm_ref_state_type s;
  fnm_ref_state_type next_s;
  logic ref_rise;
  logic ref_fall;
  logic ref_event;
  logic ref_tick;
  logic ref_halver_bit;
  logic [9:0] r_eff;

  // ----------------------------------------------------------------------
  // Reference path
  // ----------------------------------------------------------------------
  // Edges are taken from the second and third stages only, so the first
  // synchroniser stage never feeds logic
  // Limitation: a pin held high through reset shows one rising edge after
  // release; with a free-running reference that costs one early wrap at most
  always_comb begin
    next_s = s;
    next_s.ref_s1 = REF_IN;
    next_s.ref_s2 = s.ref_s1;
    next_s.ref_s3 = s.ref_s2;
    ref_rise = s.ref_s2 & ~s.ref_s3;
    ref_fall = ~s.ref_s2 & s.ref_s3;
    // Counting both edges doubles the rate seen by the counter
    ref_event = ref_rise | (DOUBLER_EN & ref_fall); // R4
    ref_halver_bit = REF_CONFIG_WORD[REF_HALVER_POS]; // R13
    r_eff = fnm_eff_count(REF_CONFIG_WORD[REF_COUNT_MSB:REF_COUNT_LSB]); // R14
    ref_tick = 1'b0;
    if (ref_event) begin
      if (s.cnt >= r_eff - 10'h001) begin // R3
        next_s.cnt = REF_COUNT_RESET;
        ref_tick = 1'b1;
      end else begin
        next_s.cnt = s.cnt + 10'h001;
      end
    end
    // Toggle stage; its output is square whatever the counter duty
    if (ref_tick) begin
      next_s.tgl = ~s.tgl; // R6 R13
    end
    // Without the halver the compare clock is the counter's one-cycle pulse
    next_s.cmp_clk = ref_halver_bit ? next_s.tgl : ref_tick; // R2
    next_s.cmp_tick = ref_halver_bit ? (ref_tick & ~s.tgl) : ref_tick; // R2 R10
  end

  // State register
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      s <= REF_STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign COMPARE_CLK = s.cmp_clk;
  assign COMPARE_TICK = s.cmp_tick;

  // ----------------------------------------------------------------------
  // Modulator
  // ----------------------------------------------------------------------
  // One modulator step per compare cycle; the denominator is not tied to
  // the reference settings, so any compare rate can pair with any modulus
  fnm_sdm u_sdm (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .advance(s.cmp_tick), // R10
    .load(LOAD),
    .dither_en(DITHER_EN),
    .int_value(INT_VALUE),
    .numerator_value(NUMERATOR_VALUE), // R16
    .denominator_value(DENOMINATOR_VALUE), // R7
    .phase_word(PHASE_WORD),
    .divide_value(FB_DIVIDE)
  );

  // ----------------------------------------------------------------------
  // Assertion helpers
  // ----------------------------------------------------------------------
  // Counts reference events between counter wraps; armed only after a wrap
  // seen with unchanged settings, since a change mid-count is legal
  logic [10:0] ev_cnt;
  logic chk_arm;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ev_cnt <= 11'h000;
      chk_arm <= 1'b0;
    end else begin
      if (ref_event) begin
        ev_cnt <= ref_tick ? 11'h000 : ev_cnt + 11'h001;
      end
      if (!$stable(REF_CONFIG_WORD) || !$stable(DOUBLER_EN)) begin
        chk_arm <= 1'b0;
      end else if (ref_tick) begin
        chk_arm <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  property p_ref_ratio;
    (ref_tick && chk_arm && $stable(REF_CONFIG_WORD))
      |-> (ev_cnt + 11'h001 == {1'b0, r_eff});
  endproperty
  a_ref_ratio: assert property (p_ref_ratio) else $error("reference ratio wrong"); // R3 R14

  property p_double;
    (DOUBLER_EN && ref_fall) |-> ref_event;
  endproperty
  a_double: assert property (p_double) else $error("falling edge not counted"); // R4

  property p_single;
    (!DOUBLER_EN && ref_fall) |-> !ref_event;
  endproperty
  a_single: assert property (p_single) else $error("falling edge counted"); // R4

  property p_halver;
    (ref_halver_bit && $stable(ref_halver_bit) && ref_tick) ##1 $stable(ref_halver_bit)
      |-> (COMPARE_CLK != $past(COMPARE_CLK));
  endproperty
  a_halver: assert property (p_halver) else $error("halver did not toggle"); // R6 R13

  property p_halver_hold;
    (ref_halver_bit && $stable(ref_halver_bit) && !ref_tick) ##1 $stable(ref_halver_bit)
      |-> $stable(COMPARE_CLK);
  endproperty
  a_halver_hold: assert property (p_halver_hold) else $error("halver moved"); // R6

  property p_direct;
    (!ref_halver_bit) |=> (COMPARE_CLK == $past(ref_tick)) && (COMPARE_TICK == COMPARE_CLK);
  endproperty
  a_direct: assert property (p_direct) else $error("direct path wrong"); // R2

  property p_tick_rise;
    (ref_halver_bit && $stable(ref_halver_bit)) ##1 ref_halver_bit
      |-> (COMPARE_TICK == $rose(COMPARE_CLK));
  endproperty
  a_tick_rise: assert property (p_tick_rise) else $error("tick off rising edge"); // R10

  // Counter stepping and wrap, plus the load path to the feedback divider;
  // these hold whatever the settings, so they need no arming
  property p_count_step;
    (ref_event && !ref_tick) |=> (s.cnt == $past(s.cnt) + 10'h001);
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not step"); // R3

  property p_count_hold;
    !ref_event |=> $stable(s.cnt);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("counter moved idle"); // R3

  property p_wrap_clear;
    ref_tick |=> (s.cnt == REF_COUNT_RESET);
  endproperty
  a_wrap_clear: assert property (p_wrap_clear) else $error("counter not cleared"); // R3

  property p_tick_source;
    COMPARE_TICK |-> $past(ref_tick);
  endproperty
  a_tick_source: assert property (p_tick_source) else $error("tick without wrap"); // R10

  property p_load_int;
    LOAD |=> (FB_DIVIDE == {1'b0, $past(INT_VALUE)});
  endproperty
  a_load_int: assert property (p_load_int) else $error("load did not set divide"); // R1

  c_halved: cover property (ref_halver_bit && COMPARE_TICK);
  c_doubled: cover property (DOUBLER_EN && ref_fall && ref_tick);
  c_direct: cover property (!ref_halver_bit && COMPARE_TICK);

endmodule

// ==== hdl/fnm_sdm.sv ====
/*
  Third-order MASH sigma-delta modulator with a programmable modulus and an
  optional pseudo-random dither, producing the feedback divide value.
  Assumes advance pulses come from the compare-clock tick of the same
  clock domain, and that the seed phase word is below the denominator.
*/
`timescale 1ns/100ps
module fnm_sdm
  import fnm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic advance,
  input wire logic load,
  input wire logic dither_en,
  // Ratio
  input wire logic [15:0] int_value,
  input wire logic [11:0] numerator_value,
  input wire logic [11:0] denominator_value,
  input wire logic [11:0] phase_word,
  // Feedback counter
  output logic [16:0] divide_value
);

  fnm_sdm_state_type s;
  fnm_sdm_state_type next_s;
  logic [11:0] m;
  logic dith;
  logic [12:0] r1;
  logic [12:0] r2;
  logic [12:0] r3;
  logic signed [4:0] y;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Loading reseeds everything so the spur pattern is repeatable per seed
  always_comb begin
    next_s = s;
    m = fnm_eff_denom(denominator_value); // R7 R8
    dith = dither_en & s.lfsr[0];
    r1 = fnm_mod_add(s.acc1, {1'b0, numerator_value} + {12'h000, dith}, m);
    r2 = fnm_mod_add(s.acc2, {1'b0, r1[11:0]}, m);
    r3 = fnm_mod_add(s.acc3, {1'b0, r2[11:0]}, m);
    // Noise-shaped carry sum, range -3 to +4
    y = {4'h0, r1[12]} + {4'h0, r2[12]} - {4'h0, s.c2_d} + {4'h0, r3[12]}
        - {3'h0, s.c3_d, 1'b0} + {4'h0, s.c3_dd}; // R11
    if (load) begin
      next_s = SDM_STATE_RESET;
      next_s.acc1 = dither_en ? ACC_RESET : phase_word; // R15
      next_s.div = {1'b0, int_value};
    end else if (advance) begin // R10
      next_s.acc1 = r1[11:0];
      next_s.acc2 = r2[11:0];
      next_s.acc3 = r3[11:0];
      next_s.c2_d = r2[12];
      next_s.c3_d = r3[12];
      next_s.c3_dd = s.c3_d;
      next_s.div = {1'b0, int_value} + {{12{y[4]}}, y}; // R1
      // Stepping only on advance stretches the sequence to the LFSR period
      next_s.lfsr = {s.lfsr[19:0], s.lfsr[LFSR_TAP_A] ^ s.lfsr[LFSR_TAP_B]}; // R12
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= SDM_STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign divide_value = s.div;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_acc_bound;
    ($past(advance) && !$past(load) && $stable(denominator_value)
     && ($past(s.acc1) < m)) |-> (s.acc1 < m);
  endproperty
  a_acc_bound: assert property (p_acc_bound) else $error("acc1 left modulus"); // R8

  property p_seed;
    (load && !dither_en) |=> (s.acc1 == $past(phase_word));
  endproperty
  a_seed: assert property (p_seed) else $error("seed not loaded"); // R15

  property p_div_range;
    (advance && !load) |=> ((divide_value <= {1'b0, $past(int_value)} + 17'h00004)
      && (divide_value + 17'h00003 >= {1'b0, $past(int_value)}));
  endproperty
  a_div_range: assert property (p_div_range) else $error("divide out of range"); // R1 R11

  property p_hold;
    (!advance && !load) |=> $stable(s);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved without advance"); // R10

  property p_lfsr_live;
    s.lfsr != 21'h000000;
  endproperty
  a_lfsr_live: assert property (p_lfsr_live) else $error("dither LFSR stuck"); // R12

  c_carry: cover property (advance && r3[12]);
  c_dither: cover property (advance && dith);

endmodule

// ==== verification/fnm_fb_model.sv ====
/*
  Model of the phase detector and feedback counter: times compare periods
  and high phases, and takes each new divide value once it has settled.
  Assumes the same clock domain as the core under test.
*/
`timescale 1ns/100ps
module fnm_fb_model
  import fnm_pkg::*;
(
  // Clock
  input wire logic clk,
  // Core outputs
  input wire logic compare_clk,
  input wire logic compare_tick,
  input wire logic [16:0] fb_divide,
  // Measurements
  output logic [15:0] tick_gap,
  output logic [15:0] high_len,
  output logic step_seen,
  output logic [16:0] step_val
);
  // ----------------------------------------------------------------
  // Period, duty and divide capture
  // ----------------------------------------------------------------
  logic [15:0] gap_cnt = 16'h0000;
  logic [15:0] hi_cnt = 16'h0000;
  logic tick_d = 1'b0;

  // The counter loads the new ratio one cycle after the tick, so sample late
  always @(posedge clk) begin
    tick_d <= compare_tick;
    step_seen <= tick_d;
    if (tick_d) begin
      step_val <= fb_divide;
    end
    gap_cnt <= compare_tick ? 16'h0001 : gap_cnt + 16'h0001;
    if (compare_tick) begin
      tick_gap <= gap_cnt;
    end
    if (compare_clk) begin
      hi_cnt <= hi_cnt + 16'h0001;
    end else if (hi_cnt != 16'h0000) begin
      high_len <= hi_cnt;
      hi_cnt <= 16'h0000;
    end
  end
endmodule

// ==== verification/test_fnm_ref_path_mod.sv ====
/*
  Bench for the fractional-N core: drives a reference square wave and
  ratio settings, checks compare timing and the divide value sequence.
  Assumes fnm_fb_model as the far side; one clock domain.
*/
`timescale 1ns/100ps
module test_fnm_ref_path_mod
  import fnm_pkg::*;
  ;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [15:0] INTV = 16'h0100;
  localparam logic [11:0] DENS [4] = '{12'h002, 12'h009, 12'h006, 12'h005};
  localparam int LENS [4] = '{4, 27, 36, 5};
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic ref_in = 1'b0;
  logic [1:0] ref_ph = 2'h0;
  logic [31:0] ref_config_word = 32'h00004000;
  logic doubler_en = 1'b0;
  logic [11:0] numerator_value = 12'h001;
  logic [11:0] denominator_value = 12'h005;
  logic [11:0] phase_word = 12'h000;
  logic dither_en = 1'b0;
  logic load = 1'b0;
  logic [15:0] int_value = INTV;
  logic compare_clk;
  logic compare_tick;
  logic [16:0] fb_divide;
  logic [15:0] tick_gap;
  logic [15:0] high_len;
  logic step_seen;
  logic [16:0] step_val;
  logic [31:0] bad = 32'h00000000;
  logic [31:0] sum;
  logic [31:0] diff;
  logic [16:0] seq[$];
  logic [16:0] keep[$];
  int num_errors = 0;
  int samples_checked = 0;

  // 125 MHz system clock
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  // Reference of 8 cycles; doubled, the compare rate stays below 32 MHz
  always @(posedge clk_sys) begin
    ref_ph <= ref_ph + 2'h1;
    if (ref_ph == 2'h3) begin
      ref_in <= ~ref_in;
    end
  end

  fnm_ref_path_mod uut (.CLK_SYS(clk_sys), .RST_N(rst_n), .REF_IN(ref_in),
    .REF_CONFIG_WORD(ref_config_word), .DOUBLER_EN(doubler_en), .INT_VALUE(int_value),
    .NUMERATOR_VALUE(numerator_value), .DENOMINATOR_VALUE(denominator_value),
    .PHASE_WORD(phase_word), .DITHER_EN(dither_en), .LOAD(load),
    .COMPARE_CLK(compare_clk), .COMPARE_TICK(compare_tick), .FB_DIVIDE(fb_divide));

  fnm_fb_model fb (.clk(clk_sys), .compare_clk(compare_clk), .compare_tick(compare_tick),
    .fb_divide(fb_divide), .tick_gap(tick_gap), .high_len(high_len),
    .step_seen(step_seen), .step_val(step_val));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Leading negedge keeps one tick pulse from being counted twice
  task automatic wait_tick(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      @(negedge clk_sys);
      while (compare_tick !== 1'b1 && k < 20000) begin
        @(negedge clk_sys);
        k++;
      end
      if (k >= 20000) begin
        num_errors++;
      end
    end
  endtask

  // Unused word bits set to ones, so only the count and halver fields count
  task automatic set_ref(input logic [9:0] r, input logic h, input logic d, input int gap);
    @(posedge clk_sys);
    ref_config_word <= {7'h7F, h, r, 14'h3FFF};
    doubler_en <= d;
    wait_tick(3);
    repeat (2) @(negedge clk_sys);
    check(tick_gap, gap);
  endtask

  // Load aligned to a tick so the collected sequence starts at the seed
  task automatic run_mod(input logic [11:0] den, input logic [11:0] num,
                         input logic [11:0] ph, input logic dith, input int n);
    int k;
    seq.delete();
    wait_tick(1);
    @(posedge clk_sys);
    denominator_value <= den;
    numerator_value <= num;
    phase_word <= ph;
    dither_en <= dith;
    load <= 1'b1;
    @(posedge clk_sys);
    load <= 1'b0;
    @(negedge clk_sys);
    check(fb_divide, {1'b0, int_value});
    repeat (3) @(negedge clk_sys);
    k = 0;
    while (seq.size() < n && k < 100000) begin
      @(negedge clk_sys);
      if (step_seen === 1'b1) begin
        seq.push_back(step_val);
        bad = bad + ((step_val < int_value - 17'h3 || step_val > int_value + 17'h4) ? 1 : 0);
      end
      k++;
    end
    if (seq.size() < n) begin
      num_errors++;
    end
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    check({compare_clk, compare_tick, fb_divide}, 0);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    set_ref(10'h001, 1'b0, 1'b0, 8);
    set_ref(10'h3FF, 1'b0, 1'b1, 4092);
    set_ref(10'h003, 1'b0, 1'b1, 12);
    set_ref(10'h005, 1'b1, 1'b0, 80);
    check(high_len, 40);
    set_ref(10'h001, 1'b0, 1'b1, 4);
    set_ref(10'h000, 1'b0, 1'b1, 4);
    for (int i = 0; i < 4; i++) begin
      run_mod(DENS[i], DENS[i] - 12'h001, 12'h000, 1'b0, 2 * LENS[i]);
      sum = 0;
      diff = 0;
      for (int j = 0; j < LENS[i]; j++) begin
        sum = sum + seq[j] - INTV;
        diff = diff + ((seq[j] !== seq[j + LENS[i]]) ? 1 : 0);
      end
      check(sum, LENS[i] * (DENS[i] - 1) / DENS[i]);
      check(diff, 0);
    end
    check(bad, 0);
    run_mod(12'h005, 12'h001, 12'h000, 1'b0, 5);
    keep = seq;
    run_mod(12'h005, 12'h001, 12'h003, 1'b0, 5);
    diff = 0;
    for (int j = 0; j < 5; j++) begin
      diff = diff + ((seq[j] !== keep[j]) ? 1 : 0);
    end
    check(diff != 0, 1);
    // Top of the integer range pushes the divide value into its bit 16
    @(posedge clk_sys);
    int_value <= 16'hFFFE;
    run_mod(12'h032, 12'h001, 12'h000, 1'b1, 200);
    check(bad, 0);
    diff = 0;
    for (int j = 0; j < 100; j++) begin
      diff = diff + ((seq[j] !== seq[j + 100]) ? 1 : 0);
    end
    check(diff != 0, 1);
    close_out();
  end

  // Watchdog well beyond the expected run of some 14000 cycles
  initial begin
    repeat (80000) @(posedge clk_sys);
    num_errors++;
    close_out();
  end
endmodule
